/* File: design/tsfr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tsfr_fifo #(
   parameter int DATA_W = 20
) (
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire logic              smp_valid,
   output logic                   smp_ready,
   input  wire logic [3:0]        measurement_slot,
   input  wire logic              smp_dark,
   input  wire logic              ambient_cancel_overflow,
   input  wire logic              exposure_overflow,
   input  wire logic              smp_spike,
   input  wire logic [DATA_W-1:0] smp_computed,
   input  wire logic [DATA_W-1:0] smp_raw,
   input  wire logic [8:0]        measurement_slot_enable,
   input  wire logic [3:0]        spike_detect_slot_select,
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_wdata,
   output logic [7:0]             reg_rdata,
   output logic                   raw_capture_select,
   output logic [7:0]             queue_threshold
);
   localparam int WORD_W = DATA_W + 4;

   typedef struct packed {
      logic [7:0]        write_slot_index;
      logic [7:0]        read_slot_index;
      logic [8:0]        avail;
      logic [6:0]        lost_item_tally;
      logic [7:0]        threshold;
      logic              raw;
      logic              status_clear_on_read;
      logic              afull_type;
      logic              rollover_control;
      logic [1:0]        byte_idx;
      logic [WORD_W-1:0] hold;
      logic              hold_empty;
      logic [7:0]        rdata;
      logic [WORD_W-1:0] buf0;
      logic [WORD_W-1:0] buf1;
      logic [1:0]        buf_cnt;
   } tsfr_state_t;

   tsfr_state_t       st_ff;
   tsfr_state_t       nxt_st;
   // The memory has no reset; the item count alone says which words are valid.
   logic [WORD_W-1:0] mem [0:255];
   logic              mem_we;

   // Builds the stored word from the sample and its events.
   function automatic logic [WORD_W-1:0] tsfr_word(
      input logic [3:0]        slot,
      input logic              dark,
      input logic              alc,
      input logic              expo,
      input logic              spike,
      input logic              raw,
      input logic [3:0]        sel,
      input logic [DATA_W-1:0] comp,
      input logic [DATA_W-1:0] rawv
   );
      logic [3:0] tag;
      logic       spike_ok;
      spike_ok = spike && !raw && (slot == sel);
      tag = slot;
      // Later tests override earlier ones, so the order below is the priority.
      if (dark && raw) begin
         tag = tsfr_pkg::TAG_DARK;
      end
      if (expo) begin
         tag = tsfr_pkg::TAG_EXPOSURE_OVERFLOW;
      end
      if (alc) begin
         tag = tsfr_pkg::TAG_AMBIENT_CANCEL_OVERFLOW;
      end
      if (spike_ok) begin
         tag = tsfr_pkg::TAG_SPIKE;
      end
      return {tag, (raw ? rawv : comp)};
   endfunction : tsfr_word

   function automatic logic [7:0] tsfr_byte(
      input logic [WORD_W-1:0] w,
      input logic [1:0]        idx
   );
      logic [23:0] full;
      full = 24'(w);
      case (idx)
         2'h0:    return full[23:16];
         2'h1:    return full[15:8];
         default: return full[7:0];
      endcase
   endfunction : tsfr_byte

   // Samples of disabled slots are not queued unless dark; queued items are read out in arrival order.
   function automatic logic tsfr_slot_ok(
      input logic [3:0] slot,
      input logic       dark,
      input logic [8:0] enables
   );
      logic ok;
      ok = dark;
      if (slot >= tsfr_pkg::SLOT_FIRST && slot <= tsfr_pkg::SLOT_LAST) begin
         ok = ok || enables[4'(slot - tsfr_pkg::SLOT_FIRST)];
      end
      return ok;
   endfunction : tsfr_slot_ok

   // The lost-item tally stops at its maximum instead of wrapping to zero.
   function automatic logic [6:0] tsfr_tally_inc(
      input logic [6:0] tally
   );
      logic [6:0] nxt;
      nxt = tally;
      if (tally != tsfr_pkg::TALLY_MAX) begin
         nxt = tally + 7'h01;
      end
      return nxt;
   endfunction : tsfr_tally_inc

   // Both queue indices wrap from the last slot back to slot zero.
   function automatic logic [7:0] tsfr_idx_inc(
      input logic [7:0] idx
   );
      return idx + 8'h01;
   endfunction : tsfr_idx_inc

   // The third byte of a burst returns the position to the first byte.
   function automatic logic [1:0] tsfr_next_byte(
      input logic [1:0] idx
   );
      logic [1:0] nxt;
      nxt = idx + 2'h1;
      if (idx == tsfr_pkg::LAST_BYTE) begin
         nxt = tsfr_pkg::FIRST_BYTE;
      end
      return nxt;
   endfunction : tsfr_next_byte

   // Control readback; the purge strobe is never stored and reads as zero.
   function automatic logic [7:0] tsfr_ctrl_byte(
      input logic raw,
      input logic stat_clr,
      input logic afull,
      input logic rollover
   );
      logic [7:0] val;
      val = tsfr_pkg::RESET_BYTE;
      val[tsfr_pkg::BIT_RAW_CAPTURE] = raw;
      val[tsfr_pkg::BIT_STAT_CLEAR]  = stat_clr;
      val[tsfr_pkg::BIT_AFULL_TYPE]  = afull;
      val[tsfr_pkg::BIT_ROLLOVER]    = rollover;
      return val;
   endfunction : tsfr_ctrl_byte

   logic              drain;
   logic              slot_ok;
   logic              take;
   logic              host_pop;
   logic              full;
   logic [WORD_W-1:0] head_word;
   logic [WORD_W-1:0] in_word;
   logic [WORD_W-1:0] cur_word;
   logic              cur_empty;
   logic              pop_rd;
   logic              buf_out_valid;
   logic              buf_out_ready;

   assign smp_ready          = (st_ff.buf_cnt != tsfr_pkg::BUF_SLOTS);
   assign raw_capture_select = st_ff.raw;
   assign queue_threshold    = st_ff.threshold;
   assign reg_rdata          = st_ff.rdata;

   always_comb begin
      nxt_st    = st_ff;
      slot_ok   = tsfr_slot_ok(measurement_slot, smp_dark, measurement_slot_enable);
      take      = smp_valid && smp_ready;
      in_word   = tsfr_word(measurement_slot, smp_dark, ambient_cancel_overflow,
                            exposure_overflow, smp_spike, st_ff.raw,
                            spike_detect_slot_select, smp_computed, smp_raw);
      head_word = st_ff.buf0;
      full      = (st_ff.avail == tsfr_pkg::QUEUE_DEPTH);
      pop_rd    = reg_rd && (reg_addr == tsfr_pkg::ADDR_POP_PORT);
      cur_word  = (st_ff.byte_idx == 2'h0) ? mem[st_ff.read_slot_index] : st_ff.hold;
      cur_empty = (st_ff.byte_idx == 2'h0) ? (st_ff.avail == 9'h000) : st_ff.hold_empty;
      if (cur_empty) begin
         cur_word = {tsfr_pkg::TAG_INVALID, DATA_W'(0)};
      end
      host_pop  = pop_rd && (st_ff.byte_idx == tsfr_pkg::LAST_BYTE) && !cur_empty;
      buf_out_valid = (st_ff.buf_cnt != 2'h0);
      // The write side waits while an item leaves so index updates never collide.
      buf_out_ready = !host_pop;
      drain         = buf_out_valid && buf_out_ready;
      mem_we    = 1'b0;

      if (drain) begin
         nxt_st.buf0 = st_ff.buf1;
         if (full && !st_ff.rollover_control) begin
            nxt_st.lost_item_tally = tsfr_tally_inc(st_ff.lost_item_tally);
         end else begin
            mem_we = 1'b1;
            nxt_st.write_slot_index = tsfr_idx_inc(st_ff.write_slot_index);
            if (full) begin
               // Rollover discards the oldest item to make room.
               nxt_st.read_slot_index = tsfr_idx_inc(st_ff.read_slot_index);
               nxt_st.lost_item_tally = tsfr_tally_inc(st_ff.lost_item_tally);
            end else begin
               nxt_st.avail = st_ff.avail + 9'h001;
            end
         end
      end

      case ({take && slot_ok, drain})
         2'b10: begin
            if (st_ff.buf_cnt == 2'h0) begin
               nxt_st.buf0 = in_word;
            end else begin
               nxt_st.buf1 = in_word;
            end
            nxt_st.buf_cnt = st_ff.buf_cnt + 2'h1;
         end
         2'b11: begin
            if (st_ff.buf_cnt == 2'h1) begin
               nxt_st.buf0 = in_word;
            end else begin
               nxt_st.buf1 = in_word;
            end
         end
         2'b01: nxt_st.buf_cnt = st_ff.buf_cnt - 2'h1;
         default: ;
      endcase

      if (reg_rd) begin
         case (reg_addr)
            tsfr_pkg::ADDR_WR_INDEX:   nxt_st.rdata = st_ff.write_slot_index;
            tsfr_pkg::ADDR_RD_INDEX:   nxt_st.rdata = st_ff.read_slot_index;
            tsfr_pkg::ADDR_TALLY_HIGH: nxt_st.rdata = {st_ff.avail[8], st_ff.lost_item_tally};
            tsfr_pkg::ADDR_COUNT_LOW:  nxt_st.rdata = st_ff.avail[7:0];
            tsfr_pkg::ADDR_POP_PORT:   nxt_st.rdata = tsfr_byte(cur_word, st_ff.byte_idx);
            tsfr_pkg::ADDR_THRESHOLD:  nxt_st.rdata = st_ff.threshold;
            tsfr_pkg::ADDR_CONTROL:    nxt_st.rdata = tsfr_ctrl_byte(st_ff.raw,
                                          st_ff.status_clear_on_read, st_ff.afull_type,
                                          st_ff.rollover_control);
            default: nxt_st.rdata = tsfr_pkg::RESET_BYTE;
         endcase
         // Any read away from the data port abandons a partial burst.
         if (pop_rd) begin
            nxt_st.hold       = cur_word;
            nxt_st.hold_empty = cur_empty;
            nxt_st.byte_idx   = tsfr_next_byte(st_ff.byte_idx);
         end else begin
            nxt_st.byte_idx = 2'h0;
         end
      end

      if (host_pop) begin
         nxt_st.read_slot_index = tsfr_idx_inc(st_ff.read_slot_index);
         nxt_st.avail           = st_ff.avail - 9'h001;
         nxt_st.lost_item_tally = 7'h00;
      end

      if (reg_wr) begin
         case (reg_addr)
            tsfr_pkg::ADDR_RD_INDEX: begin
               nxt_st.read_slot_index = reg_wdata;
               nxt_st.byte_idx        = 2'h0;
            end
            tsfr_pkg::ADDR_THRESHOLD: nxt_st.threshold = reg_wdata;
            tsfr_pkg::ADDR_CONTROL: begin
               nxt_st.raw                  = reg_wdata[tsfr_pkg::BIT_RAW_CAPTURE];
               nxt_st.status_clear_on_read = reg_wdata[tsfr_pkg::BIT_STAT_CLEAR];
               nxt_st.afull_type           = reg_wdata[tsfr_pkg::BIT_AFULL_TYPE];
               nxt_st.rollover_control     = reg_wdata[tsfr_pkg::BIT_ROLLOVER];
               // The purge bit is never stored, so it reads back as zero.
               if (reg_wdata[tsfr_pkg::BIT_PURGE]) begin
                  nxt_st.write_slot_index = 8'h00;
                  nxt_st.read_slot_index  = 8'h00;
                  nxt_st.avail            = 9'h000;
                  nxt_st.lost_item_tally  = 7'h00;
                  nxt_st.byte_idx         = 2'h0;
                  nxt_st.buf_cnt          = 2'h0;
                  mem_we                  = 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         mem[st_ff.write_slot_index] <= head_word;
      end
   end
endmodule : tsfr_fifo
`default_nettype wire

/* File: design/tsfr_pkg.sv */
package tsfr_pkg;
   localparam logic [7:0] ADDR_WR_INDEX   = 8'h04;
   localparam logic [7:0] ADDR_RD_INDEX   = 8'h05;
   localparam logic [7:0] ADDR_TALLY_HIGH = 8'h06;
   localparam logic [7:0] ADDR_COUNT_LOW  = 8'h07;
   localparam logic [7:0] ADDR_POP_PORT   = 8'h08;
   localparam logic [7:0] ADDR_THRESHOLD  = 8'h09;
   localparam logic [7:0] ADDR_CONTROL    = 8'h0A;

   localparam int BIT_RAW_CAPTURE = 7;
   localparam int BIT_PURGE       = 4;
   localparam int BIT_STAT_CLEAR  = 3;
   localparam int BIT_AFULL_TYPE  = 2;
   localparam int BIT_ROLLOVER    = 1;

   localparam logic [3:0] TAG_DARK    = 4'hA;
   localparam logic [3:0] TAG_AMBIENT_CANCEL_OVERFLOW = 4'hB;
   localparam logic [3:0] TAG_EXPOSURE_OVERFLOW = 4'hC;
   localparam logic [3:0] TAG_SPIKE   = 4'hD;
   localparam logic [3:0] TAG_INVALID = 4'hE;

   localparam logic [6:0] TALLY_MAX    = 7'h7F;
   localparam logic [1:0] LAST_BYTE    = 2'h2;
   localparam logic [1:0] FIRST_BYTE   = 2'h0;
   localparam logic [1:0] BUF_SLOTS    = 2'h2;
   localparam logic [3:0] SLOT_FIRST   = 4'h1;
   localparam logic [3:0] SLOT_LAST    = 4'h9;
   localparam logic [8:0] QUEUE_DEPTH  = 9'h100;
   localparam logic [7:0] RESET_BYTE   = 8'h00;
endpackage : tsfr_pkg

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
   logic        ref_clk, reset, reg_wr, reg_rd, smp_valid, smp_ready, smp_dark, smp_spike, ok;
   logic        ambient_cancel_overflow, exposure_overflow, raw_capture_select;
   logic [3:0]  measurement_slot, spike_detect_slot_select;
   logic [8:0]  measurement_slot_enable;
   logic [19:0] smp_computed, smp_raw;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, queue_threshold, b;
   logic [23:0] w;
   int          err_total, comparisons;
   tsfr_fifo tsfr_fifo_inst (.ref_clk, .reset, .smp_valid, .smp_ready, .measurement_slot,
      .smp_dark, .ambient_cancel_overflow, .exposure_overflow, .smp_spike, .smp_computed,
      .smp_raw, .measurement_slot_enable, .spike_detect_slot_select, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .raw_capture_select, .queue_threshold);
   tsfr_sample_src tsfr_sample_src_inst (.ref_clk, .smp_ready, .smp_valid, .measurement_slot,
      .smp_dark, .ambient_cancel_overflow, .exposure_overflow, .smp_spike, .smp_computed,
      .smp_raw);
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic wr(input logic [7:0] a, d);
      @(posedge ref_clk);
      #2 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #2 reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #2 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #2 reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd
   task automatic chk(input logic [7:0] a, e);
      rd(a, b);
      `CHK("register", e, b)
   endtask : chk
   task automatic pop(input logic [23:0] e);
      rd(8'h08, w[23:16]);
      rd(8'h08, w[15:8]);
      rd(8'h08, w[7:0]);
      `CHK("item", e, w)
   endtask : pop
   task automatic put(input logic [3:0] s, f, input logic [19:0] c);
      tsfr_sample_src_inst.push(s, f, c, ok);
      if (!ok) err_total++;
   endtask : put
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      final_report();
   end
   initial begin
      {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h40000;
      measurement_slot_enable = 9'h1FF;
      spike_detect_slot_select = 4'h3;
      err_total = 0;
      comparisons = 0;
      repeat (8) @(posedge ref_clk);
      #2 reset = 1'b0;
      chk(8'h04, 8'h00);
      chk(8'h20, 8'h00);
      wr(8'h09, 8'h5A);
      `CHK("threshold", 8'h5A, queue_threshold)
      put(4'h1, 4'h0, 20'h80001);
      put(4'h2, 4'h2, 20'h12345);
      put(4'h3, 4'h6, 20'h23456);
      put(4'h3, 4'h7, 20'h34567);
      put(4'h4, 4'h1, 20'h45678);
      put(4'h9, 4'h0, 20'h56789);
      repeat (4) @(posedge ref_clk);
      chk(8'h04, 8'h06);
      chk(8'h07, 8'h06);
      chk(8'h06, 8'h00);
      pop({4'h1, 20'h80001});
      pop({4'hC, 20'h12345});
      pop({4'hB, 20'h23456});
      pop({4'hD, 20'h34567});
      pop({4'h4, 20'h45678});
      chk(8'h05, 8'h05);
      wr(8'h05, 8'h04);
      chk(8'h05, 8'h04);
      pop({4'h4, 20'h45678});
      wr(8'h0A, 8'h10);
      chk(8'h07, 8'h00);
      chk(8'h05, 8'h00);
      chk(8'h04, 8'h00);
      pop({4'hE, 20'h00000});
      chk(8'h05, 8'h00);
      measurement_slot_enable = 9'h1EF;
      wr(8'h0A, 8'h90);
      `CHK("raw select", 1'b1, raw_capture_select)
      chk(8'h0A, 8'h80);
      put(4'h3, 4'h1, 20'h0ABCD);
      put(4'h2, 4'h8, 20'h11111);
      put(4'h5, 4'h0, 20'h33333);
      put(4'h6, 4'h0, 20'h22222);
      repeat (4) @(posedge ref_clk);
      chk(8'h07, 8'h03);
      pop({4'h3, 20'hF5432});
      pop({4'hA, 20'hEEEEE});
      pop({4'h6, 20'hDDDDD});
      wr(8'h0A, 8'h00);
      for (int i = 0; i < 400; i++) put(4'h1, 4'h0, 20'(i));
      repeat (4) @(posedge ref_clk);
      chk(8'h06, 8'hFF);
      chk(8'h07, 8'h00);
      chk(8'h04, 8'h03);
      pop({4'h1, 20'h00000});
      chk(8'h06, 8'h00);
      chk(8'h07, 8'hFF);
      chk(8'h05, 8'h04);
      wr(8'h0A, 8'h02);
      put(4'h2, 4'h0, 20'h77777);
      put(4'h2, 4'h0, 20'h88888);
      repeat (4) @(posedge ref_clk);
      chk(8'h05, 8'h05);
      chk(8'h06, 8'h81);
      chk(8'h04, 8'h05);
      pop({4'h1, 20'h00002});
      final_report();
   end
endmodule : tb
`default_nettype wire

/* File: sim/tsfr_fifo_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tsfr_fifo_chk (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       smp_ready,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       raw_capture_select,
   input wire logic [7:0] queue_threshold
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   ready_after_reset_a: assert property ($fell(reset) |-> smp_ready)
      else $error("buffer not ready after reset");
   raw_select_a: assert property (reg_wr && reg_addr == 8'h0A
      |=> raw_capture_select == $past(reg_wdata[7])) else $error("raw select not taken");
   threshold_copy_a: assert property (reg_wr && reg_addr == 8'h09
      |=> queue_threshold == $past(reg_wdata)) else $error("threshold not taken");
   read_data_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   purge_self_clear_a: assert property (reg_rd && reg_addr == 8'h0A |=> !reg_rdata[4])
      else $error("purge bit reads back set");
   purge_count_a: assert property (reg_wr && reg_addr == 8'h0A && reg_wdata[4] ##2
      reg_rd && reg_addr == 8'h07 |=> reg_rdata == 8'h00) else $error("count after purge");
   read_index_a: assert property (reg_wr && reg_addr == 8'h05 ##2
      reg_rd && reg_addr == 8'h05 |=> reg_rdata == $past(reg_wdata, 3)) else $error("rd index");
endmodule : tsfr_fifo_chk
bind tsfr_fifo tsfr_fifo_chk tsfr_fifo_chk_inst (.ref_clk(ref_clk), .reset(reset),
   .smp_ready(smp_ready), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .raw_capture_select(raw_capture_select),
   .queue_threshold(queue_threshold));
`default_nettype wire

/* File: sim/tsfr_sample_src.sv */
`timescale 1ns/1ps
`default_nettype none
module tsfr_sample_src (
   input  wire logic        ref_clk,
   input  wire logic        smp_ready,
   output logic             smp_valid,
   output logic [3:0]       measurement_slot,
   output logic             smp_dark,
   output logic             ambient_cancel_overflow,
   output logic             exposure_overflow,
   output logic             smp_spike,
   output logic [19:0]      smp_computed,
   output logic [19:0]      smp_raw
);
   initial begin
      smp_valid = 1'b0;
      {measurement_slot, smp_dark, ambient_cancel_overflow, exposure_overflow, smp_spike} = 8'h00;
      smp_computed = 20'h00000;
      smp_raw = 20'hFFFFF;
   end
   // Flags f are dark, ambient overflow, exposure overflow, spike; raw data is ~c.
   task automatic push(input logic [3:0] s, f, input logic [19:0] c, output bit ok);
      int n;
      @(posedge ref_clk);
      #2 smp_valid = 1'b1;
      {measurement_slot, smp_dark, ambient_cancel_overflow, exposure_overflow, smp_spike} = {s, f};
      smp_computed = c;
      smp_raw = ~c;
      for (n = 0; smp_ready !== 1'b1 && n < 20; n++) begin
         @(posedge ref_clk);
         #2;
      end
      ok = n < 20;
      @(posedge ref_clk);
      #2 smp_valid = 1'b0;
      // Released data no longer shows the last word.
      smp_computed = ~smp_computed;
      smp_raw = ~smp_raw;
   endtask : push
endmodule : tsfr_sample_src
`default_nettype wire
